/* cit_code_rom.sv */
`timescale 1ns/100ps
module cit_code_rom (
    input wire logic [5:0] pc, // fetch address driven by the bench
    output logic [7:0] code_byte // first instruction byte at that address
);
    localparam int N = 43;
    // listing: moves, alu, bit ops, branches, test-and-clear, movx forms
    localparam logic [7:0] CODE [0:N-1] = '{
        8'hE8, 8'hA8, 8'h85, 8'h90, 8'h93, 8'h83, 8'hC0, 8'hD0, 8'h73,
        8'h23, 8'h33, 8'h03, 8'h13, 8'hC4,
        8'h04, 8'h14, 8'h08, 8'h18, 8'h05, 8'h15, 8'h06, 8'h16,
        8'hC2, 8'hD2, 8'hB2, 8'hC3, 8'hD3, 8'hB3,
        8'h11, 8'h12, 8'h22, 8'h32, 8'hB5, 8'hB4, 8'hB8, 8'hB6, 8'hD8, 8'hD5,
        8'h10, 8'hE2, 8'hE0, 8'hF2, 8'hF0};
    // past the listing the memory returns an unused opcode
    assign code_byte = (pc < 6'(N)) ? CODE[pc] : 8'hA5;
endmodule // cit_code_rom

/* cit_pkg.sv */
package cit_pkg;
    typedef logic [7:0] cit_op_t;
    typedef logic [4:0] cit_cyc_t;
    typedef logic [1:0] cit_len_t;
    typedef enum logic [1:0] {CIT_IDLE, CIT_BUSY} cit_state_e;
endpackage

/* cit_regs.svh */
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH
// external access cycle base counts
`define CIT_EXT_BASE_MODE0 5'h05
`define CIT_EXT_BASE_MODE1 5'h03
// on-chip auxiliary ram access length
`define CIT_AUX_CYCLES 5'h03
// stretch field widths
`define CIT_ALE_W 2
`define CIT_RWP_W 3
// test-bit-and-clear opcode
`define CIT_OP_JBC 8'h10
`endif

/* cit_timing.sv */
`timescale 1ns/100ps
`include "cit_regs.svh"
module cit_timing (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic issue_valid, // opcode presented for execution
    input wire logic [7:0] issue_opcode, // first instruction byte
    input wire logic movx_external, // movx targets external ram
    input wire logic external_access_mode_select, // external access mode
    input wire logic [`CIT_ALE_W-1:0] ale_stretch, // latch pulse stretch
    input wire logic [`CIT_RWP_W-1:0] rw_stretch, // read/write pulse stretch
    input wire logic rw_setup_hold_stretch, // setup/hold stretch
    input wire logic tested_bit, // value of bit tested by test-and-clear
    output logic issue_ready, // sequencer accepts an opcode
    output logic [1:0] instr_bytes, // length of accepted instruction
    output logic [4:0] instr_cycles, // cycle count of accepted instruction
    output logic bit_clear, // pulse: clear the tested bit
    output logic busy // instruction in progress
);
    cit_pkg::cit_state_e state_reg;
    cit_pkg::cit_cyc_t remain_reg;
    cit_pkg::cit_cyc_t cyc_now;
    cit_pkg::cit_len_t len_now;
    logic take;

    function automatic cit_pkg::cit_cyc_t ext_cycles(input logic mode,
            input logic [`CIT_ALE_W-1:0] ale, input logic [`CIT_RWP_W-1:0] rw,
            input logic sh);
        cit_pkg::cit_cyc_t sh2;
        sh2 = {3'h0, sh, 1'h0};
        if (mode) begin
            ext_cycles = `CIT_EXT_BASE_MODE1 + {2'h0, rw} + sh2;
        end else begin
            ext_cycles = `CIT_EXT_BASE_MODE0 + {2'h0, ale, 1'h0} + {2'h0, rw}
                + sh2;
        end
    endfunction

    // opcode to length and cycle count
    function automatic void decode(input cit_pkg::cit_op_t op, input logic ext,
            input cit_pkg::cit_cyc_t xc, output cit_pkg::cit_len_t len,
            output cit_pkg::cit_cyc_t cyc);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        len = 2'h1;
        cyc = 5'h01;
        if (lo == 4'h1) begin
            len = 2'h2;
            cyc = 5'h06;
            if (!hi[0]) begin
                cyc = 5'h03;
            end
        end else if (lo >= 4'h8) begin
            unique case (hi)
                4'h0, 4'h1: cyc = 5'h03;
                4'h2, 4'h3, 4'h4, 4'h5, 4'h6: cyc = 5'h02;
                4'h7: begin len = 2'h2; cyc = 5'h02; end
                4'h8: begin len = 2'h2; cyc = 5'h03; end
                4'h9: cyc = 5'h02;
                4'hA: begin len = 2'h2; cyc = 5'h04; end
                4'hB: begin len = 2'h3; cyc = 5'h04; end
                4'hC: cyc = 5'h03;
                4'hD: begin len = 2'h2; cyc = 5'h04; end
                4'hE: cyc = 5'h01;
                4'hF: cyc = 5'h02;
            endcase
        end else if (lo >= 4'h6) begin
            unique case (hi)
                4'h0, 4'h1: cyc = 5'h04;
                4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: cyc = 5'h03;
                4'h7, 4'hA: begin len = 2'h2; cyc = 5'h03; end
                4'h8: begin len = 2'h2; cyc = 5'h04; end
                4'hB: begin len = 2'h3; cyc = 5'h05; end
                4'hC, 4'hD: cyc = 5'h04;
                4'hE: cyc = 5'h02;
                4'hF: cyc = 5'h03;
            endcase
        end else begin
            unique case (op)
                8'h00: cyc = 5'h01;
                8'h02: begin len = 2'h3; cyc = 5'h04; end
                8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4: cyc = 5'h01;
                8'h04, 8'h14: cyc = 5'h02;
                8'h05, 8'h15: begin len = 2'h2; cyc = 5'h04; end
                8'h10: begin len = 2'h3; cyc = 5'h05; end
                8'h12: begin len = 2'h3; cyc = 5'h06; end
                8'h20, 8'h30: begin len = 2'h3; cyc = 5'h04; end
                8'h22, 8'h32: cyc = 5'h04;
                8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h94: begin
                    len = 2'h2; cyc = 5'h02; end
                8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95: begin
                    len = 2'h2; cyc = 5'h03; end
                8'h40, 8'h50, 8'h60, 8'h70, 8'h80: begin len = 2'h2; cyc = 5'h03; end
                8'h42, 8'h52, 8'h62, 8'h92, 8'hB2, 8'hC2, 8'hD2: begin
                    len = 2'h2; cyc = 5'h04; end
                8'h43, 8'h53, 8'h63: begin len = 2'h3; cyc = 5'h04; end
                8'h72, 8'h82, 8'hA0, 8'hA2, 8'hB0, 8'hD0: begin
                    len = 2'h2; cyc = 5'h03; end
                8'h73: cyc = 5'h03;
                8'h74: begin len = 2'h2; cyc = 5'h02; end
                8'h75: begin len = 2'h3; cyc = 5'h03; end
                8'h83, 8'h93: cyc = 5'h04;
                8'h84: cyc = 5'h05;
                8'h85: begin len = 2'h3; cyc = 5'h04; end
                8'h90: begin len = 2'h3; cyc = 5'h03; end
                8'hA3: cyc = 5'h01;
                8'hA4, 8'hD4: cyc = 5'h04;
                8'hB3, 8'hC3, 8'hD3: cyc = 5'h01;
                8'hB4: begin len = 2'h3; cyc = 5'h04; end
                8'hB5: begin len = 2'h3; cyc = 5'h05; end
                8'hC0: begin len = 2'h2; cyc = 5'h04; end
                8'hC5: begin len = 2'h2; cyc = 5'h04; end
                8'hD5: begin len = 2'h3; cyc = 5'h05; end
                8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
                    cyc = ext ? xc : `CIT_AUX_CYCLES; end
                8'hE5: begin len = 2'h2; cyc = 5'h02; end
                8'hF4: cyc = 5'h02;
                8'hF5: begin len = 2'h2; cyc = 5'h03; end
                default: begin len = 2'h1; cyc = 5'h01; end
            endcase
        end
    endfunction

    always_comb begin
        decode(issue_opcode, movx_external,
            ext_cycles(external_access_mode_select, ale_stretch, rw_stretch,
                rw_setup_hold_stretch), len_now, cyc_now);
    end

    assign issue_ready = (state_reg == cit_pkg::CIT_IDLE);
    assign take = issue_valid && issue_ready;
    assign busy = (state_reg == cit_pkg::CIT_BUSY);

    // sequencer: counts down the listed cycles before accepting again
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= cit_pkg::CIT_IDLE;
            remain_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                cit_pkg::CIT_IDLE: begin
                    if (take && cyc_now > 5'h01) begin
                        state_reg <= cit_pkg::CIT_BUSY;
                        remain_reg <= cyc_now - 5'h01;
                    end
                end
                cit_pkg::CIT_BUSY: begin
                    remain_reg <= remain_reg - 5'h01;
                    if (remain_reg == 5'h01) begin
                        state_reg <= cit_pkg::CIT_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            instr_bytes <= 2'h0;
            instr_cycles <= 5'h00;
        end else if (take) begin
            instr_bytes <= len_now;
            instr_cycles <= cyc_now;
        end
    end

    // clear the tested bit, registered to the cycle after the accepting cycle, when it is found set
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_clear <= 1'b0;
        end else begin
            bit_clear <= take && (issue_opcode == `CIT_OP_JBC) && tested_bit;
        end
    end

    logic [4:0] busy_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_cnt <= 5'h00;
        end else if (take) begin
            busy_cnt <= 5'h01;
        end else if (busy) begin
            busy_cnt <= busy_cnt + 5'h01;
        end
    end

    wait_full_a: assert property (@(posedge clk) disable iff (rst)
        (issue_ready && !$past(issue_ready) && !$past(rst)) |-> (busy_cnt == instr_cycles))
        else $error("sequencer freed before cycle count");
    hold_busy_a: assert property (@(posedge clk) disable iff (rst)
        busy |=> ($stable(instr_bytes) && $stable(instr_cycles)))
        else $error("opcode accepted while busy");
    mov_a_rn_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hE8)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h01 && issue_ready))
        else $error("register to acc not one cycle");
    mov_rn_dir_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hA8)
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h04))
        else $error("direct to register timing wrong");
    mov_dir_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h85)
        |=> (instr_bytes == 2'h3 && busy) ##1 busy[*2] ##1 !busy)
        else $error("direct to direct timing wrong");
    data_pointer_load_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h90)
        |=> (instr_cycles == 5'h03 && instr_bytes == 2'h3))
        else $error("data pointer load timing wrong");
    movc_data_pointer_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h93)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h04))
        else $error("pointer table lookup timing wrong");
    movc_pc_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h83)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h04))
        else $error("counter table lookup timing wrong");
    aux_len_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hE0 && !movx_external)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h03))
        else $error("auxiliary access not three cycles");
    aux_write_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hF2 && !movx_external)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h03))
        else $error("auxiliary write not three cycles");
    ext_len_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hE2 && movx_external)
        |=> (instr_bytes == 2'h1 && instr_cycles >= 5'h03 && instr_cycles <= 5'h14))
        else $error("external access length out of range");
    ext_mode1_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hE0 && movx_external && external_access_mode_select)
        |=> (instr_cycles >= 5'h03 && instr_cycles <= 5'h0C))
        else $error("mode 1 external length out of range");
    ext_mode1_exact_a: assert property (@(posedge clk) disable iff (rst)
        (take && movx_external && external_access_mode_select && issue_opcode == 8'hF2)
        |=> (instr_cycles == `CIT_EXT_BASE_MODE1 + {2'h0, $past(rw_stretch)}
            + {3'h0, $past(rw_setup_hold_stretch), 1'h0}))
        else $error("mode 1 external length wrong");
    ext_mode0_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hF0 && movx_external && !external_access_mode_select)
        |=> (instr_cycles >= 5'h05 && instr_cycles <= 5'h14))
        else $error("mode 0 external length out of range");
    ext_mode0_exact_a: assert property (@(posedge clk) disable iff (rst)
        (take && movx_external && !external_access_mode_select && issue_opcode == 8'hF2)
        |=> (instr_cycles == `CIT_EXT_BASE_MODE0 + {2'h0, $past(ale_stretch), 1'h0}
            + {2'h0, $past(rw_stretch)} + {3'h0, $past(rw_setup_hold_stretch), 1'h0}))
        else $error("mode 0 external length wrong");
    ale_max_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hF2 && movx_external && !external_access_mode_select
            && ale_stretch == 2'h3 && rw_stretch == 3'h0 && !rw_setup_hold_stretch)
        |=> (instr_cycles == 5'h0B))
        else $error("latch stretch of three not applied");
    rw_max_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hF2 && movx_external && external_access_mode_select
            && rw_stretch == 3'h7 && !rw_setup_hold_stretch)
        |=> (instr_cycles == 5'h0A))
        else $error("read write stretch of seven not applied");
    sh_one_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hF2 && movx_external && external_access_mode_select
            && rw_stretch == 3'h0 && rw_setup_hold_stretch)
        |=> (instr_cycles == 5'h05))
        else $error("setup hold stretch not applied");
    push_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hC0)
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h04))
        else $error("push timing wrong");
    pop_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hD0)
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h03))
        else $error("pop timing wrong");
    rotate_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hC4})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h01))
        else $error("rotate or swap timing wrong");
    inc_acc_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h04, 8'h14})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h02))
        else $error("acc increment timing wrong");
    inc_reg_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h08, 8'h18})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h03))
        else $error("register increment timing wrong");
    inc_dir_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h05, 8'h15})
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h04))
        else $error("direct increment timing wrong");
    inc_ind_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h06, 8'h16})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h04))
        else $error("indirect increment timing wrong");
    bit_op_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'hB2, 8'hC2, 8'hD2})
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h04))
        else $error("bit operation timing wrong");
    carry_op_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'hB3, 8'hC3, 8'hD3})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h01))
        else $error("carry operation timing wrong");
    jbc_len_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == `CIT_OP_JBC)
        |=> (instr_bytes == 2'h3 && instr_cycles == 5'h05))
        else $error("test and clear jump timing wrong");
    jbc_clear_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == `CIT_OP_JBC && tested_bit) |=> bit_clear)
        else $error("set test bit not cleared");
    bit_clr_a: assert property (@(posedge clk) disable iff (rst)
        bit_clear |-> $past(issue_opcode) == `CIT_OP_JBC && $past(tested_bit))
        else $error("bit cleared without set test bit");
    acall_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h11)
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h06))
        else $error("absolute call timing wrong");
    call_len_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h12)
        |=> (instr_cycles == 5'h06 && instr_bytes == 2'h3))
        else $error("long call timing wrong");
    ret_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'h22, 8'h32})
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h04))
        else $error("return timing wrong");
    cjne_slow_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'hB5, 8'hB6, 8'hB7})
        |=> (instr_bytes == 2'h3 && instr_cycles == 5'h05))
        else $error("slow compare jump timing wrong");
    cjne_fast_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'hB4, 8'hB8, 8'hBF})
        |=> (instr_bytes == 2'h3 && instr_cycles == 5'h04))
        else $error("fast compare jump timing wrong");
    djnz_reg_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode inside {8'hD8, 8'hDF})
        |=> (instr_bytes == 2'h2 && instr_cycles == 5'h04))
        else $error("register decrement jump timing wrong");
    djnz_dir_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'hD5)
        |=> (instr_bytes == 2'h3 && instr_cycles == 5'h05))
        else $error("direct decrement jump timing wrong");
    jmp_ind_a: assert property (@(posedge clk) disable iff (rst)
        (take && issue_opcode == 8'h73)
        |=> (instr_bytes == 2'h1 && instr_cycles == 5'h03))
        else $error("indirect jump timing wrong");
endmodule // cit_timing

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic [5:0] pc = 6'h00;
    logic [7:0] issue_opcode;
    logic movx_external = 1'b0;
    logic external_access_mode_select = 1'b0;
    logic [1:0] ale_stretch = 2'h0;
    logic [2:0] rw_stretch = 3'h0;
    logic rw_setup_hold_stretch = 1'b0;
    logic tested_bit = 1'b0;
    logic issue_ready, bit_clear, busy;
    logic [1:0] instr_bytes;
    logic [4:0] instr_cycles;
    int bad_count = 0;
    int n_checks = 0;
    int clears = 0;
    // expected length (high nibble) and cycles (low nibble) per listing address
    localparam logic [7:0] EXP [0:42] = '{
        8'h11, 8'h24, 8'h34, 8'h33, 8'h14, 8'h14, 8'h24, 8'h23, 8'h13,
        8'h11, 8'h11, 8'h11, 8'h11, 8'h11,
        8'h12, 8'h12, 8'h13, 8'h13, 8'h24, 8'h24, 8'h14, 8'h14,
        8'h24, 8'h24, 8'h24, 8'h11, 8'h11, 8'h11,
        8'h26, 8'h36, 8'h14, 8'h14, 8'h35, 8'h34, 8'h34, 8'h35, 8'h24, 8'h35,
        8'h35, 8'h13, 8'h13, 8'h13, 8'h13};
    always #5 clk = ~clk;
    always @(posedge clk) if (bit_clear === 1'b1) clears <= clears + 1;
    cit_code_rom rom (.pc(pc), .code_byte(issue_opcode));
    cit_timing DUT (.clk(clk), .rst(rst), .issue_valid(issue_valid),
        .issue_opcode(issue_opcode), .movx_external(movx_external),
        .external_access_mode_select(external_access_mode_select),
        .ale_stretch(ale_stretch), .rw_stretch(rw_stretch),
        .rw_setup_hold_stretch(rw_setup_hold_stretch), .tested_bit(tested_bit),
        .issue_ready(issue_ready), .instr_bytes(instr_bytes),
        .instr_cycles(instr_cycles), .bit_clear(bit_clear), .busy(busy));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [4:0] got, input logic [4:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // request held high through busy, so refusal and exact spacing are both exercised
    task automatic run_op(input int idx, input logic [4:0] len, input logic [4:0] cyc);
        int n;
        pc = 6'(idx);
        issue_valid = 1'b1;
        @(negedge clk);
        cmp({3'h0, instr_bytes}, len, "length");
        cmp(instr_cycles, cyc, "cycles");
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        cmp(5'(n + 1), cyc, "busy span");
        cmp({4'h0, issue_ready}, 5'h01, "ready");
    endtask
    task automatic run_range(input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            run_op(i, {1'b0, EXP[i][7:4]}, {1'b0, EXP[i][3:0]});
    endtask
    task automatic test_reset();
        cmp({4'h0, issue_ready}, 5'h01, "reset ready");
        cmp({4'h0, busy}, 5'h00, "reset busy");
        cmp({3'h0, instr_bytes}, 5'h00, "reset length");
        cmp(instr_cycles, 5'h00, "reset cycles");
        cmp({4'h0, bit_clear}, 5'h00, "reset clear");
        $display("test reset done");
    endtask
    task automatic test_moves();
        run_range(0, 8);
        $display("test moves done");
    endtask
    task automatic test_alu();
        run_range(9, 27);
        $display("test alu done");
    endtask
    task automatic test_branch();
        run_range(28, 37);
        $display("test branch done");
    endtask
    task automatic test_jbc();
        int c0;
        c0 = clears;
        tested_bit = 1'b1;
        run_op(38, 5'h03, 5'h05);
        cmp(5'(clears - c0), 5'h01, "clear pulse");
        tested_bit = 1'b0;
        run_op(38, 5'h03, 5'h05);
        cmp(5'(clears - c0), 5'h01, "no clear");
        $display("test jbc done");
    endtask
    task automatic test_aux();
        movx_external = 1'b0;
        rw_stretch = 3'h7;
        run_range(39, 42);
        $display("test aux done");
    endtask
    task automatic test_ext();
        logic [4:0] e;
        movx_external = 1'b1;
        for (int m = 0; m < 2; m++)
            for (int a = 0; a < 4; a++)
                for (int s = 0; s < 2; s++)
                    for (int r = 0; r < 8; r += 7) begin
                        external_access_mode_select = m[0];
                        ale_stretch = a[1:0];
                        rw_setup_hold_stretch = s[0];
                        rw_stretch = r[2:0];
                        e = (m == 1) ? 5'(3 + r + 2 * s) : 5'(5 + 2 * a + r + 2 * s);
                        run_op(39 + a, 5'h01, e);
                    end
        $display("test ext done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk);
        test_reset();
        rst = 1'b0;
        test_moves();
        test_alu();
        test_branch();
        test_jbc();
        test_aux();
        test_ext();
        issue_valid = 1'b0;
        summarize();
    end
endmodule // testbench
